/* include/uart_mc_pkg.sv */
// Package: register map, bit positions, bus codes and carrier types of the modem control block
package uart_mc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_MCR = 4'h0;
   localparam logic [3:0] IDX_IER = 4'h1;
   localparam logic [3:0] IDX_STATUS = 4'h2;
   // Reset values
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] IER_RESET = 8'h00;
   // Modem line control fields
   localparam int MCR_HALF = 7;
   localparam int MCR_TX_IND = 6;
   localparam int MCR_AUTO_FLOW = 5;
   localparam int MCR_LOOP = 4;
   localparam int MCR_IRQ_GATE = 3;
   localparam int MCR_USER_OUT = 2;
   localparam int MCR_RTS = 1;
   localparam int MCR_DTR = 0;
   // Interrupt and pin enable fields
   localparam int IER_SOFT_RST = 7;
   localparam int IER_TX_OE = 6;
   localparam int IER_RTS_OE = 5;
   localparam int IER_DTR_OE = 4;
   localparam int IER_MODEM_CHG = 3;
   localparam int IER_LINE_STAT = 2;
   localparam int IER_THR_EMPTY = 1;
   localparam int IER_RX_DATA = 0;
   // Writable masks: full instance and reduced instances
   localparam logic [7:0] MCR_MASK_FULL = 8'hff;
   localparam logic [7:0] MCR_MASK_LITE = 8'h08;
   localparam logic [7:0] IER_MASK_FULL = 8'h7f;
   localparam logic [7:0] IER_MASK_LITE = 8'h47;
   // Receive trigger levels in bytes, by two-bit code
   localparam logic [3:0] TRIG_CODE0 = 4'h1;
   localparam logic [3:0] TRIG_CODE1 = 4'h2;
   localparam logic [3:0] TRIG_CODE2 = 4'h4;
   localparam logic [3:0] TRIG_CODE3 = 4'h7;
   // Bus response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_HAVE_ADDR = 2'b01,
      W_HAVE_DATA = 2'b10,
      W_RESP = 2'b11
   } wr_state_t;

   // One pin driver: level and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drv_t;

   // Modem inputs, all active low
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic ri_n;
      logic dcd_n;
   } modem_in_t;

   // Interrupt sources from the rest of the UART
   typedef struct packed {
      logic rx_data;
      logic line_status;
      logic thr_empty;
      logic cts_change;
      logic modem_other_change;
   } irq_src_t;
endpackage : uart_mc_pkg

/* src/uart_modem_ctrl.sv */
// Modem line control and interrupt/pin enable registers of a UART, AXI4-Lite slave
// Operation
// - Half-duplex: one shared line, transmit has priority, receive only when idle.
// - Transmit-indication bit puts transmit-busy status onto the DTR pin.
// - Auto flow control: next character starts only while CTS is low.
// - Auto flow control: CTS changes raise no modem status interrupt.
// - Auto RTS: low when receive FIFO empty, high at trigger level.
// - Loopback: all external serial output pins held inactive.
// - Loopback: TXD to RXD, RTS to CTS, DTR to DSR, outputs to RI, DCD.
// - Interrupt request forwarded only while the request gate bit is set.
// - User output bit is stored, drives no pin, seen only in loopback.
// - RTS bit set drives RTS low; clear drives high, the reset default.
// - DTR bit set drives DTR low; clear drives high, the reset default.
// - Modem features and RTS/DTR enables exist only in the first instance.
// - Writing one to soft reset pulses a UART reset, bit self-clears.
// - TXD pin driven only while its output enable bit is set.
// - RTS and DTR pins driven only while their enable bits are set.
// - Modem change interrupt only when its enable bit is set.
// - Line status interrupt only when its enable bit is set.
// - Transmit holding empty interrupt only when its enable bit is set.
// - Receive data interrupt only when its enable bit is set.
// - Receive trigger level code selects 1, 2, 4 or 7 bytes.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module uart_modem_ctrl #(
   parameter bit FIRST_INSTANCE = 1'b1,
   parameter int CNT_W = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic txd_core,
   input wire logic tx_busy,
   input wire logic [1:0] rx_trigger_level,
   input wire logic [CNT_W-1:0] rx_fifo_count,
   input wire uart_mc_pkg::irq_src_t irq_src,
   input wire uart_mc_pkg::modem_in_t modem_pins,
   input wire logic rxd_pin,
   input wire logic txd_pin_in,
   output uart_mc_pkg::pin_drv_t txd_pin,
   output uart_mc_pkg::pin_drv_t rts_n_pin,
   output uart_mc_pkg::pin_drv_t dtr_n_pin,
   output logic rxd_core,
   output uart_mc_pkg::modem_in_t modem_core,
   output logic tx_allow,
   output logic soft_reset_pulse,
   output logic irq
);
   localparam logic [7:0] MCR_MASK =
      FIRST_INSTANCE ? uart_mc_pkg::MCR_MASK_FULL : uart_mc_pkg::MCR_MASK_LITE;
   localparam logic [7:0] IER_MASK =
      FIRST_INSTANCE ? uart_mc_pkg::IER_MASK_FULL : uart_mc_pkg::IER_MASK_LITE;

   logic [7:0] modem_line_control;
   logic [7:0] interrupt_and_pin_enable;
   uart_mc_pkg::wr_state_t wr_state;
   logic [3:0] wr_index;
   logic [7:0] wr_byte;
   logic wr_lane;
   logic rts_hold;
   logic [CNT_W-1:0] trig_bytes;
   logic half_duplex_sel;
   logic tx_indicate_on_dtr;
   logic auto_flow_ctrl_en;
   logic loopback_test_en;
   logic irq_request_gate;
   logic user_modem_output;
   logic request_to_send_level;
   logic terminal_ready_level;
   logic rts_n_int;
   logic dtr_n_int;
   logic cts_n_int;
   logic aw_take;
   logic w_take;
   logic [3:0] next_index;
   logic [7:0] next_byte;
   logic next_lane;
   logic do_write;
   logic [3:0] rd_index;
   logic [7:0] rd_byte;
   logic rd_hit;

   // Field views of the control register
   assign half_duplex_sel = modem_line_control[uart_mc_pkg::MCR_HALF];
   assign tx_indicate_on_dtr = modem_line_control[uart_mc_pkg::MCR_TX_IND];
   assign auto_flow_ctrl_en = modem_line_control[uart_mc_pkg::MCR_AUTO_FLOW];
   assign loopback_test_en = modem_line_control[uart_mc_pkg::MCR_LOOP];
   assign irq_request_gate = modem_line_control[uart_mc_pkg::MCR_IRQ_GATE];
   assign user_modem_output = modem_line_control[uart_mc_pkg::MCR_USER_OUT];
   assign request_to_send_level = modem_line_control[uart_mc_pkg::MCR_RTS];
   assign terminal_ready_level = modem_line_control[uart_mc_pkg::MCR_DTR];

   // Write channel: address and data taken in either order
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign next_index = aw_take ? s_axi_awaddr[5:2] : wr_index;
   assign next_byte = w_take ? s_axi_wdata[7:0] : wr_byte;
   assign next_lane = w_take ? s_axi_wstrb[0] : wr_lane;
   assign do_write = (wr_state != uart_mc_pkg::W_RESP)
      && (aw_take || wr_state == uart_mc_pkg::W_HAVE_ADDR)
      && (w_take || wr_state == uart_mc_pkg::W_HAVE_DATA);

   // Write handshake state
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_state <= uart_mc_pkg::W_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= uart_mc_pkg::RESP_OKAY;
         wr_index <= 4'h0;
         wr_byte <= 8'h00;
         wr_lane <= 1'b0;
      end else begin
         wr_index <= next_index;
         wr_byte <= next_byte;
         wr_lane <= next_lane;
         case (wr_state)
            uart_mc_pkg::W_IDLE, uart_mc_pkg::W_HAVE_ADDR, uart_mc_pkg::W_HAVE_DATA: begin
               if (do_write) begin
                  wr_state <= uart_mc_pkg::W_RESP;
                  s_axi_awready <= 1'b0;
                  s_axi_wready <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= (next_index > uart_mc_pkg::IDX_STATUS) ?
                     uart_mc_pkg::RESP_SLVERR : uart_mc_pkg::RESP_OKAY;
               end else if (aw_take) begin
                  wr_state <= uart_mc_pkg::W_HAVE_ADDR;
                  s_axi_awready <= 1'b0;
               end else if (w_take) begin
                  wr_state <= uart_mc_pkg::W_HAVE_DATA;
                  s_axi_wready <= 1'b0;
               end else begin
                  // Ready only offered in the state that still wants the item
                  s_axi_awready <= (wr_state != uart_mc_pkg::W_HAVE_ADDR);
                  s_axi_wready <= (wr_state != uart_mc_pkg::W_HAVE_DATA);
               end
            end
            uart_mc_pkg::W_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= uart_mc_pkg::W_IDLE;
                  s_axi_bvalid <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
               end
            end
            default: begin
               wr_state <= uart_mc_pkg::W_IDLE;
            end
         endcase
      end
   end

   // Register storage; missing features of reduced instances stay zero
   // masked fields
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         modem_line_control <= uart_mc_pkg::MCR_RESET;
         interrupt_and_pin_enable <= uart_mc_pkg::IER_RESET;
      end else if (do_write && next_lane) begin
         if (next_index == uart_mc_pkg::IDX_MCR) begin
            modem_line_control <= next_byte & MCR_MASK;
         end
         if (next_index == uart_mc_pkg::IDX_IER) begin
            interrupt_and_pin_enable <= next_byte & IER_MASK;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= do_write && next_lane && next_index == uart_mc_pkg::IDX_IER
            && next_byte[uart_mc_pkg::IER_SOFT_RST];
      end
   end

   // Read path: one read at a time, answer on the next cycle
   assign rd_index = s_axi_araddr[5:2];
   assign rd_hit = rd_index <= uart_mc_pkg::IDX_STATUS;
   // readback of stored bits, reset bit reads zero
   always_comb begin
      case (rd_index)
         uart_mc_pkg::IDX_MCR: rd_byte = modem_line_control;
         uart_mc_pkg::IDX_IER: rd_byte = interrupt_and_pin_enable;
         uart_mc_pkg::IDX_STATUS: rd_byte = {rts_hold, tx_allow, modem_core, 2'h0};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= uart_mc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_hit ? uart_mc_pkg::RESP_OKAY : uart_mc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   always_comb begin
      case (rx_trigger_level)
         2'b00: trig_bytes = CNT_W'(uart_mc_pkg::TRIG_CODE0);
         2'b01: trig_bytes = CNT_W'(uart_mc_pkg::TRIG_CODE1);
         2'b10: trig_bytes = CNT_W'(uart_mc_pkg::TRIG_CODE2);
         default: trig_bytes = CNT_W'(uart_mc_pkg::TRIG_CODE3);
      endcase
   end

   // hold RTS off from trigger level until the FIFO is empty again
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rts_hold <= 1'b0;
      end else if (rx_fifo_count == '0) begin
         rts_hold <= 1'b0;
      end else if (rx_fifo_count >= trig_bytes) begin
         rts_hold <= 1'b1;
      end
   end

   // RTS active low, withdrawn while held off
   assign rts_n_int = !(request_to_send_level && !(auto_flow_ctrl_en && rts_hold));
   // DTR active low, or busy indication for a bus driver
   assign dtr_n_int = tx_indicate_on_dtr ? tx_busy : !terminal_ready_level;
   // CTS taken from own RTS in loopback
   assign cts_n_int = loopback_test_en ? rts_n_int : modem_pins.cts_n;

   // Pin drivers, registered so every output comes from a flip-flop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         txd_pin <= '{out: 1'b1, oe: 1'b0};
         rts_n_pin <= '{out: 1'b1, oe: 1'b0};
         dtr_n_pin <= '{out: 1'b1, oe: 1'b0};
      end else begin
         txd_pin.out <= loopback_test_en ? 1'b1 : txd_core;
         rts_n_pin.out <= loopback_test_en ? 1'b1 : rts_n_int;
         dtr_n_pin.out <= loopback_test_en ? 1'b1 : dtr_n_int;
         // shared line released while not sending
         txd_pin.oe <= interrupt_and_pin_enable[uart_mc_pkg::IER_TX_OE]
            && (!half_duplex_sel || tx_busy);
         rts_n_pin.oe <= interrupt_and_pin_enable[uart_mc_pkg::IER_RTS_OE];
         dtr_n_pin.oe <= interrupt_and_pin_enable[uart_mc_pkg::IER_DTR_OE];
      end
   end

   // Inputs seen by the core receiver and modem status logic
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxd_core <= 1'b1;
         modem_core <= '{cts_n: 1'b1, dsr_n: 1'b1, ri_n: 1'b1, dcd_n: 1'b1};
      end else if (loopback_test_en) begin
         // internal loop, user output visible only here
         rxd_core <= txd_core;
         modem_core <= '{cts_n: rts_n_int, dsr_n: dtr_n_int,
                         ri_n: !user_modem_output, dcd_n: !irq_request_gate};
      end else begin
         // receiver sees idle while own transmitter owns the line
         rxd_core <= half_duplex_sel ? (tx_busy ? 1'b1 : txd_pin_in) : rxd_pin;
         modem_core <= modem_pins;
      end
   end

   // next character only while CTS is asserted
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_allow <= 1'b1;
      end else begin
         tx_allow <= !auto_flow_ctrl_en || !cts_n_int;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_request_gate && (
            (irq_src.rx_data && interrupt_and_pin_enable[uart_mc_pkg::IER_RX_DATA])
            || (irq_src.thr_empty && interrupt_and_pin_enable[uart_mc_pkg::IER_THR_EMPTY])
            || (irq_src.line_status && interrupt_and_pin_enable[uart_mc_pkg::IER_LINE_STAT])
            || (interrupt_and_pin_enable[uart_mc_pkg::IER_MODEM_CHG]
                && (irq_src.modem_other_change
                    || (irq_src.cts_change && !auto_flow_ctrl_en))));
      end
   end

   // Checks
   a_irq_gate_off: assert property (@(posedge clock) disable iff (!rstn)
      !irq_request_gate |=> !irq) else $error("irq raised with gate closed");
   a_irq_needs_source: assert property (@(posedge clock) disable iff (!rstn)
      irq_request_gate && irq_src == '0 |=> !irq) else $error("irq without source");
   a_cts_irq_masked: assert property (@(posedge clock) disable iff (!rstn)
      auto_flow_ctrl_en && irq_src == 5'b00010 |=> !irq) else $error("cts change irq");
   a_soft_rst_pulse: assert property (@(posedge clock) disable iff (!rstn)
      soft_reset_pulse |=> !soft_reset_pulse && !interrupt_and_pin_enable[7])
      else $error("soft reset not a pulse");
   a_rts_level_manual: assert property (@(posedge clock) disable iff (!rstn)
      !loopback_test_en && !auto_flow_ctrl_en |=> rts_n_pin.out == !$past(request_to_send_level))
      else $error("rts level wrong");
   a_loop_pins_idle: assert property (@(posedge clock) disable iff (!rstn)
      loopback_test_en |=> txd_pin.out && rts_n_pin.out && dtr_n_pin.out)
      else $error("pin active in loopback");
   a_loop_data_path: assert property (@(posedge clock) disable iff (!rstn)
      loopback_test_en |=> rxd_core == $past(txd_core)) else $error("loop data lost");
   a_flow_stall: assert property (@(posedge clock) disable iff (!rstn)
      auto_flow_ctrl_en && cts_n_int |=> !tx_allow) else $error("tx not stalled");
   a_tx_oe_off: assert property (@(posedge clock) disable iff (!rstn)
      !interrupt_and_pin_enable[uart_mc_pkg::IER_TX_OE] |=> !txd_pin.oe)
      else $error("txd driven while disabled");
   a_rts_auto_off: assert property (@(posedge clock) disable iff (!rstn)
      auto_flow_ctrl_en && !loopback_test_en && rts_hold |=> rts_n_pin.out)
      else $error("rts not withdrawn");
   c_loopback: cover property (@(posedge clock) disable iff (!rstn)
      loopback_test_en ##1 rxd_core != rxd_pin);
   c_rts_hold: cover property (@(posedge clock) disable iff (!rstn)
      auto_flow_ctrl_en && rts_hold ##[1:50] !rts_hold);
   c_soft_reset: cover property (@(posedge clock) disable iff (!rstn) soft_reset_pulse);
   c_irq: cover property (@(posedge clock) disable iff (!rstn) !irq ##1 irq);
endmodule : uart_modem_ctrl

/* tb/remote_serial_peer.sv */
// Remote serial party on the line side of the modem control block
`timescale 1ns/100ps
module remote_serial_peer (
   input wire uart_mc_pkg::pin_drv_t rts_n_pin,
   input wire logic stall,
   output uart_mc_pkg::modem_in_t modem_pins,
   output logic rxd_pin,
   output logic peer_may_send
);
   // cross-wired handshake
   // Their request line feeds our clear line; stall models their FIFO being full
   always_comb begin
      modem_pins.cts_n = stall;
      modem_pins.dsr_n = 1'b0;
      modem_pins.ri_n = 1'b1;
      modem_pins.dcd_n = 1'b0;
   end
   // Line idles at mark; a released request line reads inactive through its pull-up
   assign rxd_pin = 1'b1;
   assign peer_may_send = rts_n_pin.oe & ~rts_n_pin.out;
endmodule : remote_serial_peer

/* tb/uart_modem_control_irq_enable_tb.sv */
// Self-checking bench for the modem control and interrupt enable registers
`timescale 1ns/100ps
module uart_modem_control_irq_enable_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] awaddr = 6'h00, araddr = 6'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   logic [1:0] r;
   logic txd_core = 1'b1, tx_busy = 1'b0, txd_pin_in = 1'b1, stall = 1'b0;
   logic [1:0] trig = 2'h0;
   logic [3:0] cnt = 4'h0;
   uart_mc_pkg::irq_src_t src = '0;
   uart_mc_pkg::modem_in_t modem_pins, modem_core;
   uart_mc_pkg::pin_drv_t txd_pin, rts_n_pin, dtr_n_pin;
   uart_mc_pkg::pin_drv_t lite_rts;
   logic [31:0] lite_rdata;
   logic rxd_pin, rxd_core, tx_allow, soft_reset_pulse, irq, peer_may_send;
   int fail_count = 0, checks = 0, cycles = 0, pulses = 0;
   logic [3:0] lvls [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
   logic [7:0] ens [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
   logic [4:0] srcs [4] = '{5'h10, 5'h04, 5'h08, 5'h01};

   // 200 MHz clock
   always #2.5 clock = ~clock;

   uart_modem_ctrl DUT (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .txd_core(txd_core), .tx_busy(tx_busy),
      .rx_trigger_level(trig), .rx_fifo_count(cnt), .irq_src(src),
      .modem_pins(modem_pins), .rxd_pin(rxd_pin), .txd_pin_in(txd_pin_in),
      .txd_pin(txd_pin), .rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin),
      .rxd_core(rxd_core), .modem_core(modem_core), .tx_allow(tx_allow),
      .soft_reset_pulse(soft_reset_pulse), .irq(irq));

   // Reduced instance on the same bus traffic; its modem features must stay absent
   uart_modem_ctrl #(.FIRST_INSTANCE(1'b0)) lite_dut (.clock(clock), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(), .s_axi_rdata(lite_rdata), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready(rready), .txd_core(txd_core), .tx_busy(tx_busy),
      .rx_trigger_level(trig), .rx_fifo_count(cnt), .irq_src(src),
      .modem_pins(modem_pins), .rxd_pin(rxd_pin), .txd_pin_in(txd_pin_in),
      .txd_pin(), .rts_n_pin(lite_rts), .dtr_n_pin(), .rxd_core(), .modem_core(),
      .tx_allow(), .soft_reset_pulse(), .irq());

   remote_serial_peer peer (.rts_n_pin(rts_n_pin), .stall(stall),
      .modem_pins(modem_pins), .rxd_pin(rxd_pin), .peer_may_send(peer_may_send));

   // Hang guard and reset pulse counter
   always @(posedge clock) begin
      cycles++;
      if (soft_reset_pulse === 1'b1) pulses++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Address and data offered together, each released when taken
   task automatic wr(input logic [3:0] idx, input logic [7:0] v);
      bit aw_done, w_done;
      @(posedge clock);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, v};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 0;
      w_done = 0;
      while (!(aw_done && w_done)) begin
         @(posedge clock);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", bresp, uart_mc_pkg::RESP_OKAY);
   endtask : wr

   task automatic rd(input logic [3:0] idx, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clock);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd

   // Registered outputs need a couple of edges to follow
   task automatic settle();
      repeat (3) @(posedge clock);
   endtask : settle

   task automatic final_report();
      if (fail_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      rd(uart_mc_pkg::IDX_MCR, d, r);
      chk("mcr_reset", d, {24'h0, uart_mc_pkg::MCR_RESET});
      chk("rts_idle", rts_n_pin, 2'b10);
      chk("dtr_idle", dtr_n_pin, 2'b10);
      // Levels and pin enables
      txd_core <= 1'b0;
      wr(uart_mc_pkg::IDX_MCR, 8'h03);
      wr(uart_mc_pkg::IDX_IER, 8'h70);
      settle();
      chk("rts_on", rts_n_pin, 2'b01);
      chk("lite_rts", lite_rts, 2'b10);
      chk("dtr_on", dtr_n_pin, 2'b01);
      chk("txd_on", txd_pin, 2'b01);
      wr(uart_mc_pkg::IDX_IER, 8'h00);
      settle();
      chk("oe_off", {txd_pin.oe, rts_n_pin.oe, dtr_n_pin.oe}, 3'b000);
      // Self-clearing reset bit
      wr(uart_mc_pkg::IDX_IER, 8'hff);
      rd(uart_mc_pkg::IDX_IER, d, r);
      chk("ier_read", d, 32'h7f);
      chk("ier_lite", lite_rdata, 32'h47);
      chk("pulses", pulses, 1);
      // Each source except the clear-line change against its enable and the request gate
      for (int i = 0; i < 4; i++) begin
         wr(uart_mc_pkg::IDX_IER, ens[i]);
         wr(uart_mc_pkg::IDX_MCR, 8'h08);
         src <= srcs[i];
         settle();
         chk("irq_en", irq, 1'b1);
         wr(uart_mc_pkg::IDX_IER, 8'h0f ^ ens[i]);
         settle();
         chk("irq_masked", irq, 1'b0);
         wr(uart_mc_pkg::IDX_IER, ens[i]);
         wr(uart_mc_pkg::IDX_MCR, 8'h00);
         settle();
         chk("irq_gate", irq, 1'b0);
      end
      // Clear-line change ignored under auto flow
      wr(uart_mc_pkg::IDX_IER, 8'h08);
      wr(uart_mc_pkg::IDX_MCR, 8'h28);
      src <= 5'h02;
      settle();
      chk("cts_chg_auto", irq, 1'b0);
      wr(uart_mc_pkg::IDX_MCR, 8'h08);
      settle();
      chk("cts_chg", irq, 1'b1);
      src <= '0;
      // Automatic request line at every trigger code
      wr(uart_mc_pkg::IDX_IER, 8'h20);
      wr(uart_mc_pkg::IDX_MCR, 8'h22);
      for (int c = 0; c < 4; c++) begin
         trig <= c[1:0];
         cnt <= lvls[c] - 4'h1;
         settle();
         chk("rts_below", peer_may_send, 1'b1);
         cnt <= lvls[c];
         settle();
         chk("rts_full", peer_may_send, 1'b0);
         if (c > 0) begin
            cnt <= lvls[c] - 4'h1;
            settle();
            chk("rts_held", peer_may_send, 1'b0);
         end
         cnt <= 4'h0;
         settle();
         chk("rts_empty", peer_may_send, 1'b1);
      end
      stall <= 1'b1;
      settle();
      chk("tx_stall", tx_allow, 1'b0);
      // Status: hold-off clear, transmit stalled, clear line high, set ready and carrier low, ring idle
      rd(uart_mc_pkg::IDX_STATUS, d, r);
      chk("status", d, 32'h28);
      chk("status_resp", r, uart_mc_pkg::RESP_OKAY);
      stall <= 1'b0;
      settle();
      chk("tx_go", tx_allow, 1'b1);
      // Internal loop
      wr(uart_mc_pkg::IDX_IER, 8'h70);
      wr(uart_mc_pkg::IDX_MCR, 8'h1f);
      settle();
      chk("loop_rxd", rxd_core, 1'b0);
      chk("loop_modem", modem_core, 4'h0);
      chk("loop_pins", {txd_pin.out, rts_n_pin.out, dtr_n_pin.out}, 3'b111);
      wr(uart_mc_pkg::IDX_MCR, 8'h10);
      settle();
      chk("user_low", modem_core, 4'hf);
      wr(uart_mc_pkg::IDX_MCR, 8'h14);
      settle();
      chk("user_high", modem_core, 4'hd);
      // Shared line and transmit indication
      wr(uart_mc_pkg::IDX_IER, 8'h50);
      wr(uart_mc_pkg::IDX_MCR, 8'hc0);
      txd_pin_in <= 1'b0;
      settle();
      chk("half_idle", {txd_pin.oe, rxd_core, dtr_n_pin.out}, 3'b000);
      tx_busy <= 1'b1;
      settle();
      chk("half_busy", {txd_pin.oe, rxd_core, dtr_n_pin.out}, 3'b111);
      rd(4'h5, d, r);
      chk("unmapped", r, uart_mc_pkg::RESP_SLVERR);
      final_report();
   end
endmodule : uart_modem_control_irq_enable_tb
